/* design/fsq_pkg.sv */
package fsq_pkg;

    // Command codes written on the data bus
    localparam logic [7:0] CMD_PROG_SETUP   = 8'h40;
    localparam logic [7:0] CMD_PROG_SETUP2  = 8'h10;
    localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
    localparam logic [7:0] CMD_CONFIRM      = 8'hd0;
    localparam logic [7:0] CMD_SUSPEND      = 8'hb0;
    localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;

    // Status word bit positions
    localparam int BIT_READY     = 7;
    localparam int BIT_ERASE_SUS = 6;
    localparam int BIT_ERASE_ERR = 5;
    localparam int BIT_PROG_ERR  = 4;
    localparam int BIT_SUPPLY    = 3;
    localparam int BIT_PROG_SUS  = 2;
    localparam int BIT_LOCKED    = 1;

    // Controller register offsets (word index on the software port)
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_ADDR   = 4'h1;
    localparam logic [3:0] REG_DATA   = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_RDATA  = 4'h4;
    localparam logic [3:0] REG_CFG    = 4'h5;

    // Operation codes written to the control register
    localparam logic [2:0] OP_PROGRAM = 3'h1;
    localparam logic [2:0] OP_ERASE   = 3'h2;
    localparam logic [2:0] OP_SUSPEND = 3'h3;
    localparam logic [2:0] OP_RESUME  = 3'h4;
    localparam logic [2:0] OP_READ    = 3'h5;
    localparam logic [2:0] OP_CLEAR   = 3'h6;
    localparam logic [2:0] OP_POLL    = 3'h7;

    // Pin timing in ns, turned into cycles at 100 MHz
    localparam int CLK_NS       = 10;
    localparam int STROBE_NS    = 70;
    localparam int STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SAMPLE_NS    = 90;
    localparam int SAMPLE_CYC   = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;

endpackage : fsq_pkg

/* design/fsq_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module fsq_sync #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Pin side and clean side
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] clean
);
    logic [WIDTH-1:0] s1;   // First stage, read only by s2
    logic [WIDTH-1:0] s2;   // Second stage
    logic [WIDTH-1:0] s3;   // Third stage

    // Three-stage capture
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Accept a change once stages two and three agree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            clean <= '0;
        end else begin
            clean <= (s2 == s3) ? s3 : clean;
        end
    end
endmodule : fsq_sync
`default_nettype wire

/* design/fsq_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module fsq_timer #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Load and expiry
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] count,
    output logic                  done
);
    logic [WIDTH-1:0] remain;   // Cycles left

    // Down counter, done while zero and not loading
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            remain <= '0;
        end else if (load) begin
            remain <= count;
        end else if (remain != '0) begin
            remain <= remain - 1'b1;
        end
    end

    assign done = (remain == '0) && !load;
endmodule : fsq_timer
`default_nettype wire

/* design/fsq_host.sv */
`timescale 1ns/1ns
`default_nettype none
module fsq_host #(
    parameter int AW = 21,
    parameter int DW = 16
) (
    // Clock and reset
    input  wire logic          CORE_CLK,
    input  wire logic          RST_B,
    // Software port
    input  wire logic [3:0]    REG_ADDR,
    input  wire logic [31:0]   REG_WDATA,
    input  wire logic          REG_WR,
    input  wire logic          REG_RD,
    output logic      [31:0]   REG_RDATA,
    // Flash control pins
    output logic               FL_CE_B,
    output logic               FL_OE_B,
    output logic               FL_WE_B,
    output logic [AW-1:0]      FL_ADDR,
    // Flash data bus, three signals
    input  wire logic [DW-1:0] FL_DQ_IN,
    output logic      [DW-1:0] FL_DQ_OUT,
    output logic               FL_DQ_OE
);
    if (AW < 2 || AW > 31 || DW < 8 || DW > 32) begin : g_bad_width
        $error("fsq_host: bus width out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // State and storage

    typedef enum logic [3:0] {
        S_IDLE, S_WR1, S_WR2, S_POLL, S_RDARR, S_DONE
    } fsq_state_t;

    fsq_state_t       state;        // Sequencer state
    fsq_state_t       next_state;
    logic [2:0]       op;           // Current operation
    logic [AW-1:0]    addr;         // Target address
    logic [DW-1:0]    wdata;        // Word to program
    logic [DW-1:0]    rdata;        // Last array word read
    logic [7:0]       status;       // Last status sampled
    logic             busy_bank;    // Bank with an operation open
    logic             op_open;      // Program or erase not yet finished
    logic             suspended;    // Operation suspended
    logic             bottom_boot;  // Boot variant
    logic [AW-1:0]    bank_split;   // First address of the upper bank
    logic             need_clear;   // Supply low seen, clear required
    logic             err;          // Request refused
    logic [1:0]       phase;        // Cycle phase inside a strobe
    logic [DW-1:0]    dq_in;        // Synchronised data bus

    ////////////////////////////////////////////////////////////////////////
    // Decoding

    function automatic logic bank_of(input logic [AW-1:0] a, input logic [AW-1:0] split);
        bank_of = (a >= split);
    endfunction : bank_of

    wire wr_ctrl   = REG_WR && (REG_ADDR == fsq_pkg::REG_CTRL);
    wire [2:0] req = REG_WDATA[2:0];
    wire query_rd  = REG_WDATA[3];
    wire req_bank  = bank_of(addr, bank_split);
    // The bank allowed to be busy during query reads
    wire query_ok  = !op_open || (bottom_boot && busy_bank == 1'b1);
    // array reads keep away from the bank of an open operation
    wire read_ok   = !op_open || (req_bank != busy_bank);
    wire strobe_end;

    fsq_sync #(.WIDTH(DW)) u_sync (
        .clk   (CORE_CLK),
        .rst_b (RST_B),
        .pin   (FL_DQ_IN),
        .clean (dq_in)
    );

    fsq_timer #(.WIDTH(8)) u_timer (
        .clk   (CORE_CLK),
        .rst_b (RST_B),
        .load  (phase == 2'd0 && state != S_IDLE && state != S_DONE),
        .count (8'(fsq_pkg::SAMPLE_CYC)),
        .done  (strobe_end)
    );

    ////////////////////////////////////////////////////////////////////////
    // Request acceptance

    // a suspend may cut into a running poll
    wire can_start = (state == S_IDLE) || (state == S_POLL && req == fsq_pkg::OP_SUSPEND
                     && (op == fsq_pkg::OP_PROGRAM || op == fsq_pkg::OP_ERASE));
    wire start_ok  =
        // refuse array reads from the busy bank
        !(req == fsq_pkg::OP_READ && !read_ok) &&
        !(need_clear && (req == fsq_pkg::OP_PROGRAM || req == fsq_pkg::OP_ERASE)) &&
        // query reads gated by boot variant
        !(req == fsq_pkg::OP_READ && query_rd && !query_ok) &&
        !((req == fsq_pkg::OP_PROGRAM || req == fsq_pkg::OP_ERASE) && op_open) &&
        !((req == fsq_pkg::OP_SUSPEND) && (!op_open || suspended)) &&
        !((req == fsq_pkg::OP_RESUME) && !suspended);

    // Sequencer transitions
    always_comb begin
        next_state = state;
        unique case (state)
            S_IDLE:  if (wr_ctrl && start_ok && req != 3'h0) begin
                         next_state = (req == fsq_pkg::OP_POLL) ? S_POLL : S_WR1;
                     end
            S_WR1:   if (strobe_end) begin
                         next_state = (op == fsq_pkg::OP_PROGRAM || op == fsq_pkg::OP_ERASE)
                                      ? S_WR2 : (op == fsq_pkg::OP_READ) ? S_RDARR : S_POLL;
                     end
            S_WR2:   if (strobe_end) begin
                         next_state = S_POLL;
                     end
            S_POLL:  if (wr_ctrl && can_start && start_ok) begin
                         next_state = S_WR1;
                     end else if (strobe_end) begin
                         next_state = (dq_in[fsq_pkg::BIT_READY]) ? S_DONE : S_POLL;
                     end
            S_RDARR: if (strobe_end) begin
                         next_state = S_DONE;
                     end
            S_DONE:  next_state = S_IDLE;
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state <= S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Phase counter within one pin cycle
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            phase <= 2'd0;
        end else if (state != next_state || state == S_IDLE || state == S_DONE) begin
            phase <= 2'd0;
        end else if (strobe_end) begin
            phase <= 2'd0;
        end else if (phase != 2'd3) begin
            phase <= phase + 2'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request capture and bookkeeping

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            op          <= 3'h0;
            addr        <= '0;
            wdata       <= '0;
            bottom_boot <= 1'b0;
            bank_split  <= '0;
            err         <= 1'b0;
        end else begin
            if (REG_WR && REG_ADDR == fsq_pkg::REG_ADDR) addr <= REG_WDATA[AW-1:0];
            if (REG_WR && REG_ADDR == fsq_pkg::REG_DATA) wdata <= REG_WDATA[DW-1:0];
            if (REG_WR && REG_ADDR == fsq_pkg::REG_CFG) begin
                bottom_boot <= REG_WDATA[0];
                bank_split  <= REG_WDATA[AW:1];
            end
            if (wr_ctrl && can_start) begin
                op  <= req;
                err <= !start_ok;
            end
        end
    end

    // Operation tracking: open, suspended, busy bank, supply-low memory
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            op_open    <= 1'b0;
            suspended  <= 1'b0;
            busy_bank  <= 1'b0;
            need_clear <= 1'b0;
        end else begin
            if (wr_ctrl && can_start && start_ok) begin
                if (req == fsq_pkg::OP_PROGRAM || req == fsq_pkg::OP_ERASE) begin
                    op_open   <= 1'b1;
                    busy_bank <= req_bank;
                end
                if (req == fsq_pkg::OP_RESUME) suspended <= 1'b0;
                if (req == fsq_pkg::OP_CLEAR) need_clear <= 1'b0;
            end
            if (state == S_POLL && strobe_end && dq_in[fsq_pkg::BIT_READY]) begin
                // suspended only when flag reads 1
                if (op == fsq_pkg::OP_SUSPEND) begin
                    suspended <= dq_in[fsq_pkg::BIT_PROG_SUS] | dq_in[fsq_pkg::BIT_ERASE_SUS];
                    op_open   <= dq_in[fsq_pkg::BIT_PROG_SUS] | dq_in[fsq_pkg::BIT_ERASE_SUS];
                end else if (op != fsq_pkg::OP_CLEAR) begin
                    op_open <= 1'b0;
                end
                if (dq_in[fsq_pkg::BIT_SUPPLY]) need_clear <= 1'b1;
            end
        end
    end

    // Sampled status and array data
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            status <= 8'h80;
            rdata  <= '0;
        end else begin
            if (state == S_POLL && strobe_end) status <= dq_in[7:0];
            if (state == S_RDARR && strobe_end) rdata <= dq_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive

    wire in_strobe = (state != S_IDLE) && (state != S_DONE) && (phase != 2'd0);
    wire [7:0] wr1_code =
        (op == fsq_pkg::OP_PROGRAM) ? fsq_pkg::CMD_PROG_SETUP :
        (op == fsq_pkg::OP_ERASE)   ? fsq_pkg::CMD_ERASE_SETUP :
        (op == fsq_pkg::OP_SUSPEND) ? fsq_pkg::CMD_SUSPEND :
        (op == fsq_pkg::OP_RESUME)  ? fsq_pkg::CMD_CONFIRM :
        (op == fsq_pkg::OP_CLEAR)   ? fsq_pkg::CMD_CLEAR_STATUS : fsq_pkg::CMD_READ_ARRAY;

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            FL_CE_B   <= 1'b1;
            FL_OE_B   <= 1'b1;
            FL_WE_B   <= 1'b1;
            FL_ADDR   <= '0;
            FL_DQ_OUT <= '0;
            FL_DQ_OE  <= 1'b0;
        end else begin
            FL_CE_B  <= !in_strobe;
            FL_OE_B  <= !(in_strobe && (state == S_POLL || state == S_RDARR));
            // write strobe for commands and data
            FL_WE_B  <= !(in_strobe && (state == S_WR1 || state == S_WR2) && phase != 2'd3);
            FL_DQ_OE <= (state == S_WR1 || state == S_WR2) && phase != 2'd0;
            FL_DQ_OUT <= (state == S_WR2)
                       ? ((op == fsq_pkg::OP_PROGRAM) ? wdata : DW'(fsq_pkg::CMD_CONFIRM))
                       : DW'(wr1_code);
            // drive the target address register in every state, polls included
            FL_ADDR  <= addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software read port

    wire [31:0] rd_mux =
        (REG_ADDR == fsq_pkg::REG_STATUS) ?
            {18'h0, need_clear, busy_bank, suspended, op_open, err,
             (state == S_IDLE), status} :
        (REG_ADDR == fsq_pkg::REG_RDATA)  ? 32'(rdata) :
        (REG_ADDR == fsq_pkg::REG_ADDR)   ? 32'(addr) :
        (REG_ADDR == fsq_pkg::REG_CTRL)   ? {29'h0, op} : 32'h0;

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            REG_RDATA <= 32'h0;
        end else begin
            REG_RDATA <= REG_RD ? rd_mux : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    oe_toggle_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (state == S_POLL && strobe_end) |=> ##[1:2] FL_OE_B)
        else $error("output enable not released between polls");

    // no program start while supply low pending
    supply_clear_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (need_clear && op_open == 1'b0) |=> !(op_open && !$past(op_open)))
        else $error("operation started with supply low pending");

    // data never driven while output enable low
    bus_fight_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        !(FL_DQ_OE && !FL_OE_B))
        else $error("data bus driven during read");

    suspend_seen_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        $rose(suspended) |-> $past(dq_in[fsq_pkg::BIT_READY]))
        else $error("suspend recorded without ready");

    resume_clear_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (wr_ctrl && can_start && start_ok && req == fsq_pkg::OP_RESUME) |=> !suspended)
        else $error("resume left suspension set");

    query_gate_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (wr_ctrl && can_start && req == fsq_pkg::OP_READ && query_rd && !query_ok)
        |=> state == S_IDLE)
        else $error("query read started while disallowed");

    erase_pair_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (state == S_WR1 && op == fsq_pkg::OP_ERASE && strobe_end) |=> state == S_WR2)
        else $error("erase confirm missing");

    ready_first_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (state == S_POLL && $past(state) == S_POLL && strobe_end && !dq_in[fsq_pkg::BIT_READY])
        |=> state == S_POLL || (state == S_WR1 && op == fsq_pkg::OP_SUSPEND))
        else $error("poll ended while busy");
endmodule : fsq_host
`default_nettype wire

/* tb/fsq_flash_model.sv */
`timescale 1ns/1ns
`default_nettype none
module fsq_flash_model #(
    parameter int            AW       = 21,
    parameter logic [AW-1:0] SPLIT    = 21'h080000,
    parameter int            PROG_NS  = 1000,
    parameter int            ERASE_NS = 3000,
    parameter int            LOCK_BLK = 5,
    parameter int            BAD_BLK  = 7,
    parameter logic [15:0]   BAD_WORD = 16'hdead
) (
    // Control pins
    input  wire logic          ce_b,
    input  wire logic          oe_b,
    input  wire logic          we_b,
    input  wire logic [AW-1:0] addr,
    // Data bus
    input  wire logic [15:0]   dq_host,
    input  wire logic          dq_oe,
    output logic      [15:0]   dq_dev,
    // Supply level and fault count
    input  wire logic          vpp_low,
    output int                 proto_err
);
    logic [15:0]   mem [int];      // Programmed words
    logic [7:0]    st   = 8'h80;   // Status byte
    logic [15:0]   q    = 16'h0;   // Latched read value
    logic [AW-1:0] op_a = '0;      // Operation address
    logic [15:0]   op_d = '0;      // Word to program
    int            left = 0;       // Busy time left
    int            pend = 0;       // 1 data next, 2 confirm next
    bit            run  = 0;       // Engine busy
    bit            susp = 0;       // Engine halted
    bit            sts_mode = 0;   // Busy bank answers status
    bit            is_erase = 0;   // Current operation kind

    initial proto_err = 0;

    function automatic bit bank(input logic [AW-1:0] a);
        return a >= SPLIT;
    endfunction : bank

    function automatic int blk(input logic [AW-1:0] a);
        return int'(a >> 15);
    endfunction : blk

    // Launch an operation
    task automatic start(input bit er);
        if (st[3]) proto_err++;
        is_erase = er;
        sts_mode = 1;
        // abort on lock or low supply
        if (vpp_low) st[3] = 1'b1;
        else if (blk(op_a) == LOCK_BLK) st[1] = 1'b1;
        else begin
            st[7] = 1'b0;
            run = 1;
            left = er ? ERASE_NS : PROG_NS;
        end
    endtask : start

    // Engine progress
    always #10 begin
        if (run && !susp) begin
            if (left > 0) left -= 10;
            else begin
                run = 0;
                st[7] = 1'b1;
                if (vpp_low) st[3] = 1'b1;
                else if (is_erase && blk(op_a) == BAD_BLK) st[5] = 1'b1;
                else if (!is_erase && op_d == BAD_WORD) st[4] = 1'b1;
                else if (!is_erase) mem[int'(addr_key(op_a))] = op_d;
            end
        end
    end

    function automatic int addr_key(input logic [AW-1:0] a);
        return int'(a);
    endfunction : addr_key

    always @(posedge we_b) begin
        if (!ce_b) begin
            if (!dq_oe) proto_err++;
            if (pend == 1) begin
                if (addr != op_a) proto_err++;
                op_d = dq_host;
                pend = 0;
                start(0);
            end else if (pend == 2) begin
                if (dq_host[7:0] != 8'hd0 || blk(addr) != blk(op_a)) proto_err++;
                pend = 0;
                start(1);
            end else begin
                case (dq_host[7:0])
                    8'h40, 8'h10: begin
                        pend = 1;
                        op_a = addr;
                    end
                    8'h20: begin
                        pend = 2;
                        op_a = addr;
                    end
                    8'hb0: if (run) begin
                        susp = 1;
                        st[7] = 1'b1;
                        st[is_erase ? 6 : 2] = 1'b1;
                    end
                    8'hd0: if (susp) begin
                        susp = 0;
                        sts_mode = 1;
                        st[7] = 1'b0;
                        st[6] = 1'b0;
                        st[2] = 1'b0;
                    end
                    8'h50: st[5:1] = '0;
                    8'hff: sts_mode = 0;
                    default: proto_err++;
                endcase
            end
        end
    end

    always @(negedge oe_b or negedge ce_b) begin
        if (!oe_b && !ce_b) begin
            if (susp && !sts_mode && blk(addr) == blk(op_a)) proto_err++;
            if (sts_mode && bank(addr) == bank(op_a)) q = {8'h00, st};
            else q = mem.exists(int'(addr)) ? mem[int'(addr)] : 16'hffff;
        end
    end

    // Released bus shows inverse of last value
    assign dq_dev = (!oe_b && !ce_b) ? q : ~q;
endmodule : fsq_flash_model
`default_nettype wire

/* tb/fsq_host_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module fsq_host_tb;
    localparam int          AW    = 21;
    localparam logic [20:0] SPLIT = 21'h080000;  // Bank boundary
    localparam logic [20:0] A0    = 21'h000100;  // Bank 0 word
    localparam logic [20:0] AB    = 21'h090000;  // Bank 1 word
    localparam logic [31:0] M     = 32'h08ff;    // Suspended and status byte
    localparam logic [3:0]  S     = fsq_pkg::REG_STATUS;

    logic          CORE_CLK  = 1'b0;
    logic          RST_B     = 1'b0;
    logic [3:0]    REG_ADDR  = '0;
    logic [31:0]   REG_WDATA = '0;
    logic          REG_WR    = 1'b0;
    logic          REG_RD    = 1'b0;
    logic [31:0]   REG_RDATA;
    logic          FL_CE_B, FL_OE_B, FL_WE_B, FL_DQ_OE;
    logic [AW-1:0] FL_ADDR;
    logic [15:0]   FL_DQ_IN, FL_DQ_OUT;
    logic          vpp_low   = 1'b0;  // Supply below threshold
    int            proto_err;         // Faults seen by the model
    int            err_total = 0;
    int            cmp_count = 0;

    always #5 CORE_CLK = ~CORE_CLK;

    fsq_host #(.AW(AW), .DW(16)) dut (
        .CORE_CLK(CORE_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .FL_CE_B(FL_CE_B), .FL_OE_B(FL_OE_B),
        .FL_WE_B(FL_WE_B), .FL_ADDR(FL_ADDR), .FL_DQ_IN(FL_DQ_IN),
        .FL_DQ_OUT(FL_DQ_OUT), .FL_DQ_OE(FL_DQ_OE));

    fsq_flash_model #(.AW(AW), .SPLIT(SPLIT)) flash (
        .ce_b(FL_CE_B), .oe_b(FL_OE_B), .we_b(FL_WE_B), .addr(FL_ADDR),
        .dq_host(FL_DQ_OUT), .dq_oe(FL_DQ_OE), .dq_dev(FL_DQ_IN),
        .vpp_low(vpp_low), .proto_err(proto_err));

    ////////////////////////////////////////////////////////////////////
    // Register port tasks
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge CORE_CLK);
        REG_ADDR  <= a;
        REG_WDATA <= d;
        REG_WR    <= 1'b1;
        @(posedge CORE_CLK);
        REG_WR <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge CORE_CLK);
        REG_ADDR <= a;
        REG_RD   <= 1'b1;
        @(posedge CORE_CLK);
        REG_RD <= 1'b0;
        #1 d = REG_RDATA;
    endtask : rd

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic chk(input logic [3:0] a, input logic [31:0] mk, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        cmp(v & mk, exp);
    endtask : chk

    // Poll the idle bit under a bound
    task automatic wait_idle;
        logic [31:0] v;
        v = '0;
        repeat (2) @(posedge CORE_CLK);
        for (int n = 0; n < 4000 && v[8] !== 1'b1; n++) rd(S, v);
        if (v[8] !== 1'b1) cmp(v, 32'h100);
    endtask : wait_idle

    task automatic op(input logic [2:0] c, input logic [20:0] a, input logic [15:0] d);
        wr(fsq_pkg::REG_ADDR, 32'(a));
        wr(fsq_pkg::REG_DATA, 32'(d));
        wr(fsq_pkg::REG_CTRL, 32'(c));
    endtask : op

    task automatic opw(input logic [2:0] c, input logic [20:0] a, input logic [15:0] d);
        op(c, a, d);
        wait_idle();
    endtask : opw

    task automatic results;
        $display("comparisons=%0d mismatches=%0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (3) @(posedge CORE_CLK);
        RST_B <= 1'b1;
        chk(S, 32'h0300, 32'h0100);
        wr(fsq_pkg::REG_CFG, 32'(SPLIT) << 1);
        // Word program, then array readback
        opw(fsq_pkg::OP_PROGRAM, A0, 16'h1234);
        chk(S, M, 32'h80);
        chk(fsq_pkg::REG_ADDR, 32'h1fffff, 32'(A0));
        opw(fsq_pkg::OP_READ, A0, 16'h0);
        chk(fsq_pkg::REG_RDATA, 32'hffff, 32'h1234);
        // Failed word stays flagged until clear
        opw(fsq_pkg::OP_PROGRAM, A0 + 2, 16'hdead);
        opw(fsq_pkg::OP_PROGRAM, A0 + 4, 16'h5678);
        chk(S, M, 32'h90);
        opw(fsq_pkg::OP_CLEAR, A0, 16'h0);
        opw(fsq_pkg::OP_PROGRAM, A0 + 6, 16'h9abc);
        chk(S, M, 32'h80);
        // Erase pass, failing block, then a good block
        opw(fsq_pkg::OP_ERASE, 21'h010000, 16'h0);
        chk(S, M, 32'h80);
        opw(fsq_pkg::OP_ERASE, 21'h038000, 16'h0);
        opw(fsq_pkg::OP_ERASE, 21'h018000, 16'h0);
        chk(S, M, 32'ha0);
        opw(fsq_pkg::OP_CLEAR, A0, 16'h0);
        // Locked block
        opw(fsq_pkg::OP_PROGRAM, 21'h028000, 16'h1111);
        chk(S, M, 32'h82);
        opw(fsq_pkg::OP_CLEAR, A0, 16'h0);
        // Low supply, refusal until cleared
        vpp_low <= 1'b1;
        opw(fsq_pkg::OP_PROGRAM, A0 + 8, 16'h2222);
        chk(S, 32'h20ff, 32'h2088);
        vpp_low <= 1'b0;
        opw(fsq_pkg::OP_PROGRAM, A0 + 10, 16'h3333);
        chk(S, 32'h0200, 32'h0200);
        opw(fsq_pkg::OP_CLEAR, A0, 16'h0);
        opw(fsq_pkg::OP_PROGRAM, A0 + 12, 16'h4444);
        chk(S, 32'h20ff, 32'h0080);
        // Suspend program then erase, read other bank, resume
        for (int k = 0; k < 2; k++) begin
            op(k ? fsq_pkg::OP_ERASE : fsq_pkg::OP_PROGRAM, AB, 16'h4321);
            repeat (40) @(posedge CORE_CLK);
            wr(fsq_pkg::REG_CTRL, 32'(fsq_pkg::OP_SUSPEND));
            wait_idle();
            chk(S, M, k ? 32'h8c0 : 32'h884);
            wr(fsq_pkg::REG_CTRL, 32'(fsq_pkg::OP_READ) | 32'h8);
            chk(S, 32'h0300, 32'h0300);
            op(fsq_pkg::OP_READ, AB, 16'h0);
            chk(S, 32'h0300, 32'h0300);
            opw(fsq_pkg::OP_READ, A0, 16'h0);
            chk(fsq_pkg::REG_RDATA, 32'hffff, 32'h1234);
            opw(fsq_pkg::OP_RESUME, AB, 16'h0);
            chk(S, M, 32'h80);
        end
        cmp(32'(proto_err), 32'h0);
        results();
    end

    // Watchdog
    initial begin
        #800000;
        err_total++;
        results();
    end
endmodule : fsq_host_tb
`default_nettype wire
